// ---- core/adcd_top.sv ----
`timescale 1ns/1ps
module adcd_top
    import adcd_pkg::*;
(
    // system clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // serial link
    input  wire logic              sclk,
    input  wire logic              chip_select_n,
    input  wire logic              sdin,
    output logic                   sdout_o,
    output logic                   sdout_oe,
    output logic                   result_ready_n,
    // converter core status and data
    input  wire logic              res_valid,
    input  wire logic [23:0]       res_data,
    input  wire logic [3:0]        res_rate,
    input  wire adcd_core_flags_t  core_flags,
    input  wire logic [3:0][23:0]  coef_active,
    // converter core control
    output logic                   conv_start,
    output logic [3:0]             conv_rate,
    output logic                   cal_start,
    output logic [1:0]             cal_type,
    output logic [3:0]             corr_disable,
    output logic                   powered_down,
    output logic                   standby_sel,
    output logic                   sync_pulse,
    output logic                   ram_access,
    output logic [4:0][7:0]        ctrl_cfg,
    output logic [3:0][23:0]       coef_host,
    output logic [15:0]            hpf_corner
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic             rst_q1_r, rst_n_r;
    logic             cs_q1_r, cs_q2_r;
    logic             tg_q1_r, tg_q2_r, tg_q3_r;
    adcd_lstate_t     st_r;
    logic [5:0]       n_r;
    logic [6:0]       sh_r;
    logic [7:0]       cmd_r;
    logic [7:0]       byte_in;
    logic [23:0]      rd_word_r;
    logic [4:0]       rd_pos_r;
    logic             rd_end_r;
    logic             sdout_r;
    adcd_evt_t        evt_r, evt_nxt;
    logic             evt_fire;
    logic             evt_tgl_r;
    logic             evt_take;
    logic             frame_s;
    logic [23:0]      live    [NSEL];
    logic [23:0]      snap_r  [NSEL];
    logic [4:0][7:0]  ctrl_r;
    logic [3:0][23:0] coef_r;
    logic [15:0]      hpf_r;
    logic [23:0]      res_r;
    logic [3:0]       res_rate_r;
    logic             rdy_n_r;
    logic             rd_err_r;
    logic             pd_r, stby_r;
    logic [3:0]       rate_r;
    logic             conv_r, cal_r, sync_r, ram_r;
    logic [15:0]      status;
    logic             wr_hit;
    logic             rd_done;
    logic [4:0]       e_addr;

    // ---------------------------------------------------------------
    // reset and frame synchronisers (system clock)
    // ---------------------------------------------------------------
    // reset release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_n_r  <= rst_q1_r;
        end
    end

    // chip select level into the system domain; freezes the read snapshot
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cs_q1_r <= 1'b1;
            cs_q2_r <= 1'b1;
        end else begin
            cs_q1_r <= chip_select_n;
            cs_q2_r <= cs_q1_r;
        end
    end
    assign frame_s = !cs_q2_r;

    // ---------------------------------------------------------------
    // link side, sampled on rising serial clock
    // ---------------------------------------------------------------
    assign byte_in = {sh_r, sdin};

    // frame state; chip select high clears it, so every frame starts fresh
    always_ff @(posedge sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            n_r       <= 6'h00;
            sh_r      <= 7'h00;
            cmd_r     <= 8'h00;
            st_r      <= LS_CMD;
            rd_word_r <= 24'h000000;
        end else begin
            if (n_r != CNT_SAT)
                n_r <= n_r + 6'h01;
            if (st_r != LS_READ)
                sh_r <= byte_in[6:0];
            if (st_r == LS_CMD && n_r == CMD_LAST) begin
                cmd_r <= byte_in;
                if (!byte_in[START_BIT] || !byte_in[MODE_BIT])
                    st_r <= LS_IDLE;
                else if (byte_in[RW_BIT]) begin
                    st_r <= LS_READ;
                    // snapshot is frozen for the whole frame, so it is stable here
                    rd_word_r <= snap_r[byte_in[SEL_MSB:SEL_LSB]]
                                 << (5'(3 - adcd_bytes(byte_in[SEL_MSB:SEL_LSB])) * 8);
                end else
                    st_r <= LS_WRITE;
            end
        end
    end

    // events for the system domain: command, committed byte, result read done
    always_comb begin
        evt_fire = 1'b0;
        evt_nxt  = evt_r;
        if (!chip_select_n && st_r == LS_CMD && n_r == CMD_LAST && byte_in[START_BIT]) begin
            evt_fire         = 1'b1;
            evt_nxt.kind     = EV_CMD;
            evt_nxt.data     = byte_in;
        end else if (!chip_select_n && st_r == LS_WRITE && n_r[2:0] == 3'h7 && n_r != CNT_SAT) begin
            evt_fire         = 1'b1;
            evt_nxt.kind     = EV_WR;
            evt_nxt.addr     = cmd_r[SEL_MSB:SEL_LSB];
            evt_nxt.byte_idx = n_r[5:3] - 3'h1;
            evt_nxt.data     = byte_in;
        end else if (!chip_select_n && st_r == LS_READ && n_r == RD_DONE_N
                     && cmd_r[SEL_MSB:SEL_LSB] == A_RESULT) begin
            evt_fire         = 1'b1;
            evt_nxt.kind     = EV_RD_DONE;
        end
    end

    // event word and toggle survive chip select; only system reset clears them
    always_ff @(posedge sclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            evt_r     <= '{kind: EV_CMD, byte_idx: 3'h0, addr: 5'h00, data: 8'h00};
            evt_tgl_r <= 1'b0;
        end else if (evt_fire) begin
            evt_r     <= evt_nxt;
            evt_tgl_r <= !evt_tgl_r;
        end
    end

    // ---------------------------------------------------------------
    // link side, output shifted on falling serial clock
    // ---------------------------------------------------------------
    // bits past the register width read as zero; read mode lasts to frame end
    always_ff @(negedge sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            rd_pos_r <= RD_MSB;
            rd_end_r <= 1'b0;
            sdout_r  <= 1'b0;
        end else if (st_r == LS_READ) begin
            sdout_r  <= rd_end_r ? 1'b0 : rd_word_r[rd_pos_r];
            if (rd_pos_r == 5'h00)
                rd_end_r <= 1'b1;
            else
                rd_pos_r <= rd_pos_r - 5'h01;
        end
    end

    assign sdout_o  = sdout_r;
    assign sdout_oe = !chip_select_n;

    // ---------------------------------------------------------------
    // event crossing into the system domain
    // ---------------------------------------------------------------
    // event word is held for eight serial clocks, far longer than the sync delay
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tg_q1_r <= 1'b0;
            tg_q2_r <= 1'b0;
            tg_q3_r <= 1'b0;
        end else begin
            tg_q1_r <= evt_tgl_r;
            tg_q2_r <= tg_q1_r;
            tg_q3_r <= tg_q2_r;
        end
    end
    assign evt_take = tg_q2_r ^ tg_q3_r;
    assign wr_hit   = evt_take && evt_r.kind == EV_WR;
    assign rd_done  = evt_take && evt_r.kind == EV_RD_DONE;
    assign e_addr   = evt_r.addr;

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    // control bytes; only writable selects respond, others drop the byte
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r)
            ctrl_r <= {5{CTRL_RST}};
        else if (wr_hit && e_addr >= A_CFG_LO && e_addr <= A_CFG_HI && evt_r.byte_idx == 3'h0)
            ctrl_r[3'(e_addr - A_CFG_LO)] <= evt_r.data;
    end

    // host coefficients, committed byte by byte so an abort keeps earlier bytes
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r)
            coef_r <= {4{COEF_RST}};
        else if (wr_hit && e_addr >= A_COEF_H && e_addr <= A_COEF_HL)
            coef_r[2'(e_addr - A_COEF_H)] <= adcd_put(coef_r[2'(e_addr - A_COEF_H)],
                                                      adcd_bytes(e_addr), evt_r.byte_idx,
                                                      evt_r.data);
    end

    // highpass corner word
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r)
            hpf_r <= HPF_RST;
        else if (wr_hit && e_addr == A_HPF)
            hpf_r <= 16'(adcd_put({8'h00, hpf_r}, adcd_bytes(A_HPF), evt_r.byte_idx, evt_r.data));
    end

    // ---------------------------------------------------------------
    // result and ready
    // ---------------------------------------------------------------
    // a new result beats a read completion in the same cycle
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            res_r      <= COEF_RST;
            res_rate_r <= RATE_RST;
            rdy_n_r    <= 1'b1;
            rd_err_r   <= 1'b0;
        end else begin
            if (res_valid) begin
                res_r      <= res_data;
                res_rate_r <= res_rate;
            end
            if (res_valid)
                rdy_n_r <= 1'b0;
            else if (rd_done)
                rdy_n_r <= 1'b1;
            if (res_valid && frame_s)
                rd_err_r <= 1'b1;
            else if (rd_done)
                rd_err_r <= 1'b0;
        end
    end
    assign result_ready_n = rdy_n_r;

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    // pulses last one system clock; power state follows only conversion bytes
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            conv_r <= 1'b0;
            cal_r  <= 1'b0;
            sync_r <= 1'b0;
            ram_r  <= 1'b0;
            pd_r   <= 1'b1;
            stby_r <= 1'b1;
            rate_r <= RATE_RST;
        end else begin
            conv_r <= 1'b0;
            cal_r  <= 1'b0;
            sync_r <= 1'b0;
            ram_r  <= 1'b0;
            if (evt_take && evt_r.kind == EV_CMD) begin
                if (!evt_r.data[MODE_BIT]) begin
                    rate_r <= evt_r.data[RATE_MSB:0];
                    pd_r   <= evt_r.data[PDN_BIT];
                    if (evt_r.data[PDN_BIT])
                        stby_r <= ctrl_r[0][SLEEP_HI:SLEEP_LO] != 2'h0;
                    // power-down wins, so a sleeping core is never asked to calibrate
                    cal_r  <= evt_r.data[CAL_BIT] && !evt_r.data[PDN_BIT];
                    conv_r <= !evt_r.data[CAL_BIT] && !evt_r.data[PDN_BIT];
                end else begin
                    // no storage behind these selects, they only trigger
                    ram_r  <= evt_r.data[SEL_MSB:SEL_LSB] == A_RAM;
                    sync_r <= evt_r.data[SEL_MSB:SEL_LSB] == A_SYNC && !evt_r.data[RW_BIT];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // read view and frozen snapshot
    // ---------------------------------------------------------------
    assign status = {core_flags.in_reset, ctrl_r[4][CALT_HI:CALT_LO] == CAL_BAD, ONES_HI,
                     pd_r ? (stby_r ? PD_STBY : PD_SLEEP) : PD_RUN, rd_err_r,
                     core_flags.analog_over, res_rate_r, core_flags.gain_over,
                     core_flags.data_over, core_flags.busy, !rdy_n_r};

    // live read value of every select; unmapped ones read zero
    always_comb begin
        for (int i = 0; i < NSEL; i++)
            live[i] = 24'h000000;
        live[A_STATUS] = {8'h00, status};
        for (int i = 0; i < 5; i++)
            live[A_CFG_LO + 5'(i)] = {16'h0000, ctrl_r[i]};
        live[A_RESULT] = res_r;
        for (int i = 0; i < 4; i++) begin
            live[A_COEF_H + 5'(i)] = coef_r[i];
            live[A_COEF_A + 5'(i)] = coef_active[i];
        end
        live[A_HPF]    = {8'h00, hpf_r};
    end

    // snapshot follows live values outside frames and holds still inside one,
    // so the serial side can load it without a multi-bit race
    for (genvar g = 0; g < NSEL; g++) begin : g_snap
        always_ff @(posedge clk or negedge rst_n_r) begin
            if (!rst_n_r)
                snap_r[g] <= COEF_RST;
            else if (!frame_s)
                snap_r[g] <= live[g];
        end
    end

    // ---------------------------------------------------------------
    // outputs to the converter core
    // ---------------------------------------------------------------
    assign conv_start   = conv_r;
    assign conv_rate    = rate_r;
    assign cal_start    = cal_r;
    assign cal_type     = ctrl_r[4][CALT_HI:CALT_LO];
    assign corr_disable = ctrl_r[4][NOCORR_HI:0];
    assign powered_down = pd_r;
    assign standby_sel  = stby_r;
    assign sync_pulse   = sync_r;
    assign ram_access   = ram_r;
    assign ctrl_cfg     = ctrl_r;
    assign coef_host    = coef_r;
    assign hpf_corner   = hpf_r;

endmodule : adcd_top

// ---- core/adcd_pkg.sv ----
package adcd_pkg;

    // ---------------------------------------------------------------
    // command byte layout
    // ---------------------------------------------------------------
    localparam int          CMD_BITS  = 8;
    localparam int          START_BIT = 7;
    localparam int          MODE_BIT  = 6;
    localparam int          CAL_BIT   = 5;
    localparam int          PDN_BIT   = 4;
    localparam int          RATE_MSB  = 3;
    localparam int          SEL_MSB   = 5;
    localparam int          SEL_LSB   = 1;
    localparam int          RW_BIT    = 0;

    // ---------------------------------------------------------------
    // register selects
    // ---------------------------------------------------------------
    localparam logic [4:0]  A_STATUS  = 5'h00;
    localparam logic [4:0]  A_CFG_LO  = 5'h01;
    localparam logic [4:0]  A_CFG_HI  = 5'h05;
    localparam logic [4:0]  A_RESULT  = 5'h06;
    localparam logic [4:0]  A_COEF_H  = 5'h07;
    localparam logic [4:0]  A_COEF_HL = 5'h0a;
    localparam logic [4:0]  A_HPF     = 5'h0b;
    localparam logic [4:0]  A_RAM     = 5'h0c;
    localparam logic [4:0]  A_SYNC    = 5'h0d;
    localparam logic [4:0]  A_COEF_A  = 5'h15;
    localparam logic [4:0]  A_COEF_AL = 5'h18;
    localparam int          NSEL      = 32;

    // ---------------------------------------------------------------
    // field positions, fixed values, reset values, counts
    // ---------------------------------------------------------------
    localparam int          SLEEP_HI  = 5;
    localparam int          SLEEP_LO  = 4;
    localparam int          CALT_HI   = 7;
    localparam int          CALT_LO   = 6;
    localparam int          NOCORR_HI = 3;
    localparam logic [1:0]  CAL_BAD   = 2'h3;
    localparam logic [1:0]  ONES_HI   = 2'h3;
    localparam logic [1:0]  PD_RUN    = 2'h0;
    localparam logic [1:0]  PD_SLEEP  = 2'h1;
    localparam logic [1:0]  PD_STBY   = 2'h2;
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [23:0] COEF_RST  = 24'h000000;
    localparam logic [15:0] HPF_RST   = 16'h0000;
    localparam logic [3:0]  RATE_RST  = 4'h9;
    localparam logic [5:0]  CMD_LAST  = 6'h07;
    localparam logic [5:0]  RD_DONE_N = 6'h1e;
    localparam logic [5:0]  CNT_SAT   = 6'h3f;
    localparam logic [4:0]  RD_MSB    = 5'h17;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {LS_CMD, LS_WRITE, LS_READ, LS_IDLE} adcd_lstate_t;
    typedef enum logic [1:0] {EV_CMD, EV_WR, EV_RD_DONE} adcd_evt_kind_t;

    typedef struct packed {
        adcd_evt_kind_t kind;
        logic [2:0]     byte_idx;
        logic [4:0]     addr;
        logic [7:0]     data;
    } adcd_evt_t;

    typedef struct packed {
        logic in_reset;
        logic analog_over;
        logic gain_over;
        logic data_over;
        logic busy;
    } adcd_core_flags_t;

    // bytes held by a select; zero for special and unmapped
    function automatic logic [1:0] adcd_bytes(input logic [4:0] a);
        if (a == A_STATUS || a == A_HPF)
            return 2'h2;
        if (a >= A_CFG_LO && a <= A_CFG_HI)
            return 2'h1;
        if ((a >= A_RESULT && a <= A_COEF_HL) || (a >= A_COEF_A && a <= A_COEF_AL))
            return 2'h3;
        return 2'h0;
    endfunction : adcd_bytes

    // place one byte, msb first, into a word of nb bytes
    function automatic logic [23:0] adcd_put(input logic [23:0] old, input logic [1:0] nb,
                                             input logic [2:0] idx, input logic [7:0] d);
        logic [23:0] w;
        logic [2:0]  pos;
        w   = old;
        pos = 3'({1'b0, nb} - idx - 3'h1);
        if (idx < {1'b0, nb})
            w[pos*8 +: 8] = d;
        return w;
    endfunction : adcd_put

endpackage : adcd_pkg

// ---- dv/adcd_top_asserts.sv ----
`timescale 1ns/1ps
module adcd_top_asserts
    import adcd_pkg::*;
(
    // clock, reset and link
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic             chip_select_n,
    input wire logic             sdout_oe,
    // converter side
    input wire logic             res_valid,
    input wire logic             result_ready_n,
    input wire logic             conv_start,
    input wire logic             cal_start,
    input wire logic             powered_down,
    input wire logic             standby_sel,
    input wire logic [1:0]       cal_type,
    input wire logic [3:0]       corr_disable,
    input wire logic [4:0][7:0]  ctrl_cfg,
    input wire logic [3:0][23:0] coef_host
);
    // ---------------------------------------------------------------
    // checks on the system clock
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [3:0] idle_r;
    // idle clocks since frame end; crossings settle well inside ten
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            idle_r <= 4'h0;
        else if (!chip_select_n)
            idle_r <= 4'h0;
        else if (idle_r != 4'hf)
            idle_r <= idle_r + 4'h1;
    end
    AST_OE_FOLLOWS_CS: assert property (sdout_oe == !chip_select_n)
        else $error("output enable does not follow chip select");
    AST_IDLE_NO_STORE: assert property (idle_r >= 4'ha |=> $stable(ctrl_cfg) && $stable(coef_host))
        else $error("stored value changed outside a frame");
    AST_CAL_FIELDS: assert property (cal_type == ctrl_cfg[4][7:6] && corr_disable == ctrl_cfg[4][3:0])
        else $error("calibration fields differ from config byte");
    AST_ONE_ACTION: assert property (!(conv_start && cal_start))
        else $error("calibration and conversion started together");
    AST_PD_NO_START: assert property ($rose(powered_down) |-> !conv_start && !cal_start)
        else $error("power down also started an action");
    AST_SLEEP_KIND: assert property ($rose(powered_down) |-> standby_sel == (ctrl_cfg[0][5:4] != 2'h0))
        else $error("sleep kind does not match config");
    AST_CONV_WAKES: assert property (conv_start |-> ##[0:2] !powered_down)
        else $error("conversion left the part powered down");
    AST_CONV_PULSE: assert property (conv_start |=> !conv_start)
        else $error("conversion start wider than one clock");
    AST_RDY_ON_RESULT: assert property (res_valid |=> !result_ready_n)
        else $error("ready not asserted after a result");
    AST_RDY_HOLDS: assert property (!result_ready_n && idle_r >= 4'ha |=> !result_ready_n)
        else $error("ready released without a result read");
endmodule : adcd_top_asserts

bind adcd_top adcd_top_asserts i_asserts (.*);

// ---- dv/adcd_host_model.sv ----
`timescale 1ns/1ps
module adcd_host_model (
    // serial link toward the device
    output logic      sclk,
    output logic      chip_select_n,
    output logic      sdin,
    input wire logic  sdout_o,
    input wire logic  sdout_oe
);
    // ---------------------------------------------------------------
    // framed transfers, 32 ns serial clock standing low between frames
    // ---------------------------------------------------------------
    initial begin
        {sclk, chip_select_n, sdin} = 3'b010;
    end
    // command byte then nd data bits taken from wd[23] down
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nd, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd};
        rd = 24'h000000;
        #5.3 chip_select_n = 1'b0;
        for (int k = 0; k < 8 + nd; k++) begin
            sdin = sh[31 - k];
            #16 sclk = 1'b1;
            // device shifts on falling, so the bit is settled here
            if (k >= 8)
                rd = {rd[22:0], sdout_oe ? sdout_o : 1'bx};
            #16 sclk = 1'b0;
        end
        #16 chip_select_n = 1'b1;
        sdin = ~sdin; // released line must not look stable
    endtask : xfer
endmodule : adcd_host_model

// ---- dv/adcd_top_bench.sv ----
`timescale 1ns/1ps
module adcd_top_bench;
    import adcd_pkg::*;
    // ---------------------------------------------------------------
    // design, host and behavioural register model
    // ---------------------------------------------------------------
    logic             clk, reset_n, sclk, chip_select_n, sdin, sdout_o, sdout_oe, result_ready_n, res_valid;
    logic             conv_start, cal_start, powered_down, standby_sel, sync_pulse, ram_access;
    logic [23:0]      res_data, rd;
    logic [3:0]       res_rate, conv_rate, corr_disable;
    logic [1:0]       cal_type;
    logic [15:0]      hpf_corner;
    logic [4:0][7:0]  ctrl_cfg;
    logic [3:0][23:0] coef_active, coef_host;
    adcd_core_flags_t core_flags;
    int               error_cnt, comparisons, n_conv, n_cal, n_sync, n_ram;
    int               mreg [0:31];
    int               pl [3] = '{7, 8, 16};
    int               ro [6] = '{0, 6, 12, 13, 21, 31};
    integer           seed = 32'hc5ae98c8;

    adcd_top        i_dut  (.*);
    adcd_host_model i_host (.*);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // pulses are one clock wide, so counts tell how many actions fired
    always @(posedge clk) begin
        n_conv += int'(conv_start === 1'b1);
        n_cal  += int'(cal_start === 1'b1);
        n_sync += int'(sync_pulse === 1'b1);
        n_ram  += int'(ram_access === 1'b1);
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    function automatic int mw(input int a);
        if (a inside {[1:5]})
            return 8;
        if (a == 0 || a == 11)
            return 16;
        return (a inside {[6:10], [21:24]}) ? 24 : 0;
    endfunction : mw
    function automatic logic [23:0] obs(input int a);
        if (a <= 5)
            return 24'(ctrl_cfg[a - 1]);
        return (a == 11) ? 24'(hpf_corner) : coef_host[a - 7];
    endfunction : obs
    // wait out the crossing before anything is compared
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input int nd);
        i_host.xfer(cmd, wd, nd, rd);
        repeat (8) @(posedge clk);
    endtask : frame
    task automatic wr(input int a, input logic [23:0] d, input int nd);
        frame(8'hc0 | 8'(a << 1), d, nd);
        for (int b = 0; (b + 1) * 8 <= nd && b * 8 < mw(a); b++)
            if (a inside {[1:5], [7:11]})
                mreg[a][mw(a) - 8 - 8 * b +: 8] = d[23 - 8 * b -: 8];
    endtask : wr
    // random noise on the input line must not disturb a read
    task automatic rdchk(input int a);
        frame(8'hc1 | 8'(a << 1), 24'($random(seed)), mw(a) == 0 ? 8 : mw(a));
        check(rd, 24'(mreg[a]));
    endtask : rdchk

    initial begin
        #500us;
        error_cnt++;
        test_done;
    end
    initial begin
        reset_n = 1'b0;
        {res_valid, res_data, res_rate, core_flags, coef_active} = '0;
        mreg = '{default: 0};
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        res_rate <= 4'($random(seed));
        core_flags <= adcd_core_flags_t'($random(seed));
        for (int i = 0; i < 4; i++) begin
            mreg[21 + i] = $random(seed) & 32'hffffff;
            coef_active[i] <= 24'(mreg[21 + i]);
        end
        repeat (3) @(posedge clk);
        check({powered_down, conv_rate}, 5'h19);
        for (int a = 1; a < 32; a++)
            if (a != 12)
                rdchk(a);
        for (int p = 0; p < 2; p++)
            for (int a = 1; a < 12; a++)
                if (a != 6) begin
                    wr(a, 24'($random(seed)), mw(a));
                    check(obs(a), 24'(mreg[a]));
                    rdchk(a);
                end
        foreach (pl[i]) begin
            wr(8, 24'($random(seed)), pl[i]);
            check(coef_host[1], 24'(mreg[8]));
        end
        foreach (ro[i])
            wr(ro[i], 24'($random(seed)), 24);
        frame(8'h4e, 24'($random(seed)), 24);
        frame(8'h09, 24'h0, 0);
        for (int a = 1; a < 12; a++)
            if (a != 6)
                check(obs(a), 24'(mreg[a]));
        check({n_sync[3:0], n_ram[3:0], n_conv[3:0]}, 12'h110);
        for (int r = 0; r < 16; r++) begin
            frame(8'h80 | 8'(r), 24'h0, 0);
            check({powered_down, conv_rate}, 24'(r));
        end
        for (int v = 0; v <= 32; v += 32) begin
            wr(1, 24'(v << 16), 8);
            frame(8'h90, 24'h0, 0);
            check({powered_down, standby_sel}, {1'b1, v != 0});
            rdchk(1);
            check(powered_down, 1'b1);
            frame(8'h85, 24'h0, 0);
            check({powered_down, conv_rate}, 5'h05);
        end
        frame(8'hb0, 24'h0, 0);
        frame(8'ha0, 24'h0, 0);
        check({n_cal[3:0], n_conv[7:0]}, 12'h112);
        check({cal_type, corr_disable}, 24'({mreg[5][7:6], mreg[5][3:0]}));
        @(posedge clk);
        res_valid <= 1'b1;
        res_data <= 24'($random(seed));
        @(posedge clk);
        res_valid <= 1'b0;
        mreg[6] = 32'(res_data);
        repeat (2) @(posedge clk);
        check(result_ready_n, 1'b0);
        for (int nd = 16; nd <= 24; nd += 8) begin
            frame(8'hcd, 24'($random(seed)), nd);
            check(rd, 24'(mreg[6] >> (24 - nd)));
            check(result_ready_n, nd == 24);
        end
        // status after a full result read: running, no read error, ready bit clear
        mreg[0] = 32'({core_flags.in_reset, mreg[5][7:6] == 2'h3, 4'hc, 1'b0, core_flags.analog_over,
                       res_rate, core_flags.gain_over, core_flags.data_over, core_flags.busy, 1'b0});
        rdchk(0);
        test_done;
    end
endmodule : adcd_top_bench
